/* mgmt_cmd_engine.sv */
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module mgmt_cmd_engine
  import mgmt_cmd_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = WRITE_TIMEOUT_CYC,
  parameter logic [7:0] MAX_BANK = 8'h01,
  parameter logic [7:0] MAX_PAGE = 8'h03,
  parameter logic [7:0] WRITABLE_START = 8'h80
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] port_link_up,
  input wire logic module_present,
  input wire logic module_resetting,
  input wire logic module_powered_down,
  input wire logic module_write_done,
  output logic module_write_req,
  output logic [31:0] module_write_target
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0] pin_meta_reg;
  logic [7:0] pin_sync_reg;
  logic [3:0] link_up;
  logic present, resetting, powered_down, wr_done;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_reg <= 8'h00;
      pin_sync_reg <= 8'h00;
    end else begin
      pin_meta_reg <= {module_write_done, module_powered_down, module_resetting,
                       module_present, port_link_up};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  assign link_up = pin_sync_reg[3:0];
  assign present = pin_sync_reg[4];
  assign resetting = pin_sync_reg[5];
  assign powered_down = pin_sync_reg[6];
  assign wr_done = pin_sync_reg[7];

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------
  logic aw_held_reg, w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [31:0] cmd_reg, param_reg, cfg_reg;
  logic [31:0] resp0_reg, resp1_reg, resp2_reg;
  logic [7:0] resp_type_reg;
  logic busy_reg, done_reg;
  logic wr_fire, start_cmd;
  logic [31:0] rd_word;
  logic rd_hit;
  cmd_state_t state_reg;

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign start_cmd = wr_fire && aw_addr_reg == ADDR_CMD && !busy_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg[7:2] <= ADDR_PINS[7:2] && aw_addr_reg[1:0] == 2'b00)
                       ? AXI_OKAY : AXI_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // a command written while busy is dropped; poll busy first
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_reg <= 32'h0000_0000;
      param_reg <= 32'h0000_0000;
      cfg_reg <= CFG_RESET;
    end else if (wr_fire) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb_reg[i]) begin
          if (aw_addr_reg == ADDR_PARAM && !busy_reg) param_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
          if (aw_addr_reg == ADDR_CFG) cfg_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
          if (start_cmd) cmd_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
        end
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ADDR_CMD: rd_word = {23'h0, cmd_reg[8:0]};
      ADDR_PARAM: rd_word = param_reg;
      ADDR_CFG: rd_word = {16'h0, cfg_reg[15:12], 1'b0, cfg_reg[10:8], 2'b00,
                           cfg_reg[5:4], 1'b0, cfg_reg[2:0]};
      ADDR_STATUS: rd_word = {16'h0, resp_type_reg, 6'h00, done_reg, busy_reg};
      ADDR_RESP0: rd_word = resp0_reg;
      ADDR_RESP1: rd_word = resp1_reg;
      ADDR_RESP2: rd_word = resp2_reg;
      ADDR_PINS: rd_word = {24'h0, pin_sync_reg};
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // link status summary
  // ---------------------------------------------------------------
  logic [2:0] nports;
  trunk_mode_t tmode;
  logic [3:0] port_speed, port_mask, trunk_bits, pct1, pct2, ch_speed;
  logic [31:0] link_word0, link_word1;

  assign nports = cfg_reg[CFG_NPORTS_LSB +: 3];
  assign tmode = trunk_mode_t'(cfg_reg[CFG_TRUNK_LSB +: 2]);
  assign port_speed = cfg_reg[CFG_SPEED_LSB +: 4];

  always_comb begin
    // every port shares one speed, so a trunk doubles per pairing
    port_mask = 4'h0;
    for (int p = 0; p < 4; p++) port_mask[p] = (p < int'(nports));
    trunk_bits = (tmode == TRUNK_NONE) ? 4'h0 : port_mask;
    pct1 = 4'h0;
    pct2 = 4'h0;
    ch_speed = port_speed;
    if (tmode == TRUNK_PAIRS) begin
      pct1 = {1'b0, link_up[0] & port_mask[0], link_up[1] & port_mask[1], 1'b0} >> 1;
      pct1 = {2'b00, pct1[1:0]} + {2'b00, pct1[1:0]} - 4'h0;
      pct1 = {1'b0, (link_up[0] & link_up[1]), (link_up[0] ^ link_up[1]), 1'b0};
      if (nports == 3'd4) begin
        pct2 = {1'b0, (link_up[2] & link_up[3]), (link_up[2] ^ link_up[3]), 1'b0};
      end
      ch_speed = (port_speed == 4'h0) ? 4'h0 : port_speed + 4'h1;
    end else if (tmode == TRUNK_ALL && nports == 3'd4) begin
      pct1 = {3'b000, link_up[0]} + {3'b000, link_up[1]} + {3'b000, link_up[2]}
             + {3'b000, link_up[3]};
      ch_speed = (port_speed == 4'h0) ? 4'h0 : port_speed + 4'h2;
    end
    if (ch_speed > MAX_SPEED_CODE) ch_speed = MAX_SPEED_CODE;
    link_word0 = {5'h00, nports, 4'h0, trunk_bits, 4'h0, link_up & port_mask,
                  pct2, pct1};
    link_word1 = 32'h0000_0000;
    if (tmode == TRUNK_NONE) begin
      for (int c = 0; c < 4; c++) begin
        if (port_mask[c] && link_up[c]) link_word1[(3-c)*8 +: 4] = port_speed;
      end
    end else begin
      link_word1[24 +: 4] = ch_speed;
      if (tmode == TRUNK_PAIRS && nports == 3'd4) link_word1[16 +: 4] = ch_speed;
    end
  end

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  logic [7:0] p_bank, p_page, p_off, p_len;
  logic [31:0] timer_reg;
  logic len_bad, loc_bad;

  assign {p_bank, p_page, p_off, p_len} = param_reg;
  assign len_bad = p_len > MAX_LEN || p_len[1:0] != 2'b00 || p_len == 8'h00;
  assign loc_bad = p_off < WRITABLE_START || ({1'b0, p_off} + {1'b0, p_len}) > PAGE_BYTES;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      resp_type_reg <= 8'h00;
      resp0_reg <= 32'h0000_0000;
      resp1_reg <= 32'h0000_0000;
      resp2_reg <= 32'h0000_0000;
      module_write_req <= 1'b0;
      module_write_target <= 32'h0000_0000;
      timer_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_cmd) begin
            state_reg <= ST_EVAL;
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
          end
        end
        ST_EVAL: begin
          state_reg <= ST_IDLE;
          busy_reg <= 1'b0;
          done_reg <= !cmd_reg[CMD_HDR_ERR_BIT];
          resp1_reg <= 32'h0000_0000;
          resp2_reg <= 32'h0000_0000;
          if (cmd_reg[7:0] == OP_MOD_WRITE) begin
            resp_type_reg <= RSP_MOD_WRITE;
            if (cfg_reg[CFG_BACKPLANE_BIT]) begin
              resp0_reg <= {RC_UNSUPPORTED, RS_UNKNOWN_CMD};
            end else if (!present) begin
              resp0_reg <= {RC_UNAVAILABLE, RS_INFO_NA};
            end else if (powered_down) begin
              resp0_reg <= {RC_FAILED, RS_NOT_POWERED};
            end else if (resetting) begin
              resp0_reg <= {RC_FAILED, RS_INFO_NA};
            end else if (p_bank > MAX_BANK || p_page > MAX_PAGE || len_bad) begin
              resp0_reg <= {RC_FAILED, RS_PARAM_INVALID};
            end else if (loc_bad) begin
              resp0_reg <= {RC_FAILED, RS_PARAM_INVALID};
            end else if (!cmd_reg[CMD_HDR_ERR_BIT]) begin
              state_reg <= ST_WRITE;
              busy_reg <= 1'b1;
              done_reg <= 1'b0;
              module_write_req <= 1'b1;
              module_write_target <= param_reg;
              timer_reg <= 32'h0000_0000;
            end
          end else if (cmd_reg[7:0] == OP_LINK_STATUS && cfg_reg[CFG_FC_NATIVE_BIT]) begin
            resp_type_reg <= RSP_LINK_STATUS;
            resp0_reg <= {RC_COMPLETED, RS_NONE};
            resp1_reg <= link_word0;
            resp2_reg <= link_word1;
          end else begin
            resp_type_reg <= cmd_reg[7:0] | RSP_FLAG;
            resp0_reg <= {RC_UNSUPPORTED, RS_UNKNOWN_CMD};
          end
        end
        ST_WRITE: begin
          timer_reg <= timer_reg + 32'h0000_0001;
          if (wr_done || timer_reg == 32'(TIMEOUT_CYCLES - 1)) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            module_write_req <= 1'b0;
            if (wr_done) begin
              resp0_reg <= {RC_COMPLETED, RS_NONE};
            end else if (cfg_reg[CFG_DELAYED_BIT]) begin
              resp0_reg <= {RC_DELAYED, RS_TIMEOUT};
            end else begin
              resp0_reg <= {RC_FAILED, RS_TIMEOUT};
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence eval_write_s;
    state_reg == ST_EVAL && cmd_reg[7:0] == OP_MOD_WRITE;
  endsequence

  a_write_type: assert property (@(posedge ref_clk) disable iff (!resetn)
    eval_write_s |=> resp_type_reg == RSP_MOD_WRITE)
    else $error("module write answered with wrong type");
  a_absent_module: assert property (@(posedge ref_clk) disable iff (!resetn)
    eval_write_s and !cfg_reg[CFG_BACKPLANE_BIT] and !present and !cmd_reg[CMD_HDR_ERR_BIT]
    |=> resp0_reg == {RC_UNAVAILABLE, RS_INFO_NA} && done_reg)
    else $error("absent module not reported");
  a_backplane_reject: assert property (@(posedge ref_clk) disable iff (!resetn)
    eval_write_s and cfg_reg[CFG_BACKPLANE_BIT] |=> resp0_reg[31:16] == RC_UNSUPPORTED)
    else $error("backplane write not rejected");
  a_powered_down: assert property (@(posedge ref_clk) disable iff (!resetn)
    eval_write_s and !cfg_reg[CFG_BACKPLANE_BIT] and present and powered_down
    |=> resp0_reg == {RC_FAILED, RS_NOT_POWERED})
    else $error("powered down module not reported");
  a_link_answer: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_reg == ST_EVAL && cmd_reg[7:0] == OP_LINK_STATUS && cfg_reg[CFG_FC_NATIVE_BIT]
    && !cmd_reg[CMD_HDR_ERR_BIT] |=> resp_type_reg == RSP_LINK_STATUS && done_reg && !busy_reg)
    else $error("link status query not answered");
  a_pct_range: assert property (@(posedge ref_clk) disable iff (!resetn)
    resp_type_reg == RSP_LINK_STATUS |-> resp1_reg[3:0] <= MAX_PCT_CODE
    && resp1_reg[7:4] <= MAX_PCT_CODE)
    else $error("trunk percentage code out of range");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    resp1_reg[15:12] == 4'h0 && resp1_reg[23:20] == 4'h0 && resp2_reg[7:4] == 4'h0
    && resp2_reg[15:12] == 4'h0 && resp2_reg[23:20] == 4'h0 && resp2_reg[31:28] == 4'h0)
    else $error("reserved response bits not zero");
  a_write_timeout: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_reg == ST_WRITE && !wr_done && timer_reg == 32'(TIMEOUT_CYCLES - 1)
    |=> resp0_reg[15:0] == RS_TIMEOUT && !module_write_req && done_reg)
    else $error("write timeout not reported");
  a_read_answer: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");

endmodule : mgmt_cmd_engine

/* mgmt_cmd_pkg.sv */
package mgmt_cmd_pkg;
  // opcodes and response packet types
  localparam logic [7:0] OP_MOD_WRITE = 8'h30;
  localparam logic [7:0] OP_LINK_STATUS = 8'h31;
  localparam logic [7:0] RSP_MOD_WRITE = 8'hB0;
  localparam logic [7:0] RSP_LINK_STATUS = 8'hB1;
  localparam logic [7:0] RSP_FLAG = 8'h80;
  // response codes
  localparam logic [15:0] RC_COMPLETED = 16'h0000;
  localparam logic [15:0] RC_FAILED = 16'h0001;
  localparam logic [15:0] RC_UNAVAILABLE = 16'h0002;
  localparam logic [15:0] RC_UNSUPPORTED = 16'h0003;
  localparam logic [15:0] RC_DELAYED = 16'h0004;
  // reason codes
  localparam logic [15:0] RS_NONE = 16'h0000;
  localparam logic [15:0] RS_PARAM_INVALID = 16'h0002;
  localparam logic [15:0] RS_INFO_NA = 16'h0006;
  localparam logic [15:0] RS_NOT_POWERED = 16'h0009;
  localparam logic [15:0] RS_TIMEOUT = 16'h000A;
  localparam logic [15:0] RS_UNKNOWN_CMD = 16'h7FFF;
  // register byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_PARAM = 8'h04;
  localparam logic [7:0] ADDR_CFG = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_RESP0 = 8'h10;
  localparam logic [7:0] ADDR_RESP1 = 8'h14;
  localparam logic [7:0] ADDR_RESP2 = 8'h18;
  localparam logic [7:0] ADDR_PINS = 8'h1C;
  // field positions
  localparam int CMD_HDR_ERR_BIT = 8;
  localparam int CFG_BACKPLANE_BIT = 0;
  localparam int CFG_FC_NATIVE_BIT = 1;
  localparam int CFG_DELAYED_BIT = 2;
  localparam int CFG_TRUNK_LSB = 4;
  localparam int CFG_NPORTS_LSB = 8;
  localparam int CFG_SPEED_LSB = 12;
  localparam logic [31:0] CFG_RESET = 32'h0000_3402;
  // payload limits
  localparam logic [7:0] MAX_LEN = 8'h80;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic [3:0] MAX_PCT_CODE = 4'h4;
  localparam logic [3:0] MAX_SPEED_CODE = 4'h8;
  // module write timeout
  localparam int CLK_PERIOD_PS = 4000;
  localparam int WRITE_TIMEOUT_US = 100;
  localparam int WRITE_TIMEOUT_CYC = (WRITE_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  typedef enum logic [1:0] {TRUNK_NONE, TRUNK_PAIRS, TRUNK_ALL} trunk_mode_t;
  typedef enum {ST_IDLE, ST_EVAL, ST_WRITE} cmd_state_t;
endpackage : mgmt_cmd_pkg

/* module_side_model.sv */
`timescale 1ns/1ps
// ------------------------------
// pluggable module far side
// ------------------------------
module module_side_model #(
  parameter int DONE_DELAY = 5
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic module_write_req,
  input wire logic [2:0] pin_mode,
  input wire logic answer_en,
  output logic module_present,
  output logic module_powered_down,
  output logic module_resetting,
  output logic module_write_done
);
  int cnt;
  assign module_present = pin_mode[2];
  assign module_powered_down = pin_mode[1];
  assign module_resetting = pin_mode[0];
  // done is a level held until the request drops; a hung module never answers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      module_write_done <= 1'b0;
    end else if (!module_write_req) begin
      cnt <= 0;
      module_write_done <= 1'b0;
    end else if (answer_en && cnt == DONE_DELAY) begin
      module_write_done <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : module_side_model

/* module_write_and_fc_link_status_tb.sv */
`timescale 1ns/1ps
module module_write_and_fc_link_status_tb;
  import mgmt_cmd_pkg::*;
  localparam int TMO = 20;
  localparam logic [31:0] OK = {RC_COMPLETED, RS_NONE};
  localparam logic [31:0] PI = {RC_FAILED, RS_PARAM_INVALID};
  localparam logic [31:0] GOOD = 32'h0103_8004;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, module_write_target, rd, st, tgt_exp;
  logic [3:0] port_link_up = 4'h0;
  logic module_present, module_resetting, module_powered_down;
  logic module_write_done, module_write_req;
  logic [2:0] pin_mode = 3'b100;
  logic answer_en = 1'b1;
  int num_errors = 0;
  int compares = 0;

  mgmt_cmd_engine #(.TIMEOUT_CYCLES(TMO)) u_mgmt_cmd_engine (
    .ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_link_up, .module_present,
    .module_resetting, .module_powered_down, .module_write_done, .module_write_req,
    .module_write_target
  );
  module_side_model u_module_side_model (
    .ref_clk, .resetn, .module_write_req, .pin_mode, .answer_en, .module_present,
    .module_powered_down, .module_resetting, .module_write_done
  );

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  // ------------------------------
  // compares and closing
  // ------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_resp

  task automatic wrap_up();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // ------------------------------
  // register bus master
  // ------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  // ------------------------------
  // command sequences
  // ------------------------------
  task automatic run_cmd(input logic [31:0] prm, input logic [7:0] op);
    int n;
    n = 0;
    tgt_exp = prm;
    axi_write(ADDR_PARAM, prm, rsp);
    axi_write(ADDR_CMD, {24'h00_0000, op}, rsp);
    do begin
      axi_read(ADDR_STATUS, st, rsp);
      n++;
    end while (st[0] !== 1'b0 && n < 100);
    chk("cmd_busy", 32'h0000_0000, {31'h0000_0000, st[0]});
    axi_read(ADDR_RESP0, rd, rsp);
  endtask : run_cmd

  // a module write carries its parameter word out to the module side
  always @(posedge ref_clk) begin
    if (module_write_req === 1'b1) begin
      chk("write_target", tgt_exp, module_write_target);
    end
  end

  task automatic wr_case(input logic [2:0] pins, input logic [31:0] prm,
                         input logic [31:0] exp, input logic [31:0] mask);
    pin_mode <= pins;
    repeat (4) @(posedge ref_clk);
    run_cmd(prm, OP_MOD_WRITE);
    chk("write_resp0", exp & mask, rd & mask);
  endtask : wr_case

  task automatic link_case(input logic [31:0] cfg, input logic [3:0] up,
                           input logic [31:0] e1, input logic [31:0] e2);
    axi_write(ADDR_CFG, cfg, rsp);
    port_link_up <= up;
    repeat (4) @(posedge ref_clk);
    run_cmd(32'h0000_0000, OP_LINK_STATUS);
    chk("link_type", {24'h00_0000, RSP_LINK_STATUS}, {24'h00_0000, st[15:8]});
    chk("link_resp0", OK, rd);
    axi_read(ADDR_RESP1, rd, rsp);
    chk("link_word1", e1, rd);
    axi_read(ADDR_RESP2, rd, rsp);
    chk("link_word2", e2, rd);
  endtask : link_case

  initial begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    axi_read(ADDR_CFG, rd, rsp);
    chk("cfg_reset", CFG_RESET, rd);
    axi_read(8'h20, rd, rsp);
    chk_resp("unmapped_read", AXI_SLVERR, rsp);
    axi_write(8'h24, 32'h0000_0001, rsp);
    chk_resp("unmapped_write", AXI_SLVERR, rsp);
    axi_write(ADDR_CFG, 32'h0000_3406, rsp);
    wr_case(3'b100, GOOD, OK, 32'hFFFF_FFFF);
    chk("write_type", {24'h00_0000, RSP_MOD_WRITE}, {24'h00_0000, st[15:8]});
    wr_case(3'b100, 32'h0000_8080, OK, 32'hFFFF_FFFF);
    wr_case(3'b000, GOOD, {RC_UNAVAILABLE, RS_INFO_NA}, 32'hFFFF_FFFF);
    wr_case(3'b110, GOOD, {RC_FAILED, RS_NOT_POWERED}, 32'hFFFF_FFFF);
    wr_case(3'b101, GOOD, {RC_FAILED, RS_INFO_NA}, 32'hFFFF_FFFF);
    wr_case(3'b100, 32'h0200_8004, PI, 32'hFFFF_FFFF);
    wr_case(3'b100, 32'h0004_8004, PI, 32'hFFFF_FFFF);
    wr_case(3'b100, 32'h0000_8006, PI, 32'hFFFF_FFFF);
    wr_case(3'b100, 32'h0000_8084, PI, 32'hFFFF_FFFF);
    wr_case(3'b100, 32'h0000_1004, PI, 32'hFFFF_FFFF);
    wr_case(3'b100, 32'h0000_8480, PI, 32'hFFFF_FFFF);
    answer_en <= 1'b0;
    wr_case(3'b100, GOOD, {16'h0000, RS_TIMEOUT}, 32'h0000_FFFF);
    chk("timeout_code", 32'h1, {31'h0, rd[31:16] === RC_FAILED || rd[31:16] === RC_DELAYED});
    axi_write(ADDR_CFG, 32'h0000_3402, rsp);
    wr_case(3'b100, GOOD, {RC_FAILED, RS_TIMEOUT}, 32'hFFFF_FFFF);
    answer_en <= 1'b1;
    axi_write(ADDR_CFG, 32'h0000_3407, rsp);
    wr_case(3'b100, GOOD, {RC_UNSUPPORTED, RS_UNKNOWN_CMD}, 32'hFFFF_FFFF);
    link_case(32'h0000_3402, 4'b1011, 32'h0400_0B00, 32'h0303_0003);
    link_case(32'h0000_3412, 4'b1011, 32'h040F_0B24, 32'h0404_0000);
    link_case(32'h0000_3422, 4'b0111, 32'h040F_0703, 32'h0500_0000);
    axi_write(ADDR_CMD, {23'h00_0000, 1'b1, OP_LINK_STATUS}, rsp);
    axi_read(ADDR_STATUS, st, rsp);
    chk("hdr_err_status", 32'h0000_0000, {30'h0000_0000, st[1:0]});
    axi_write(ADDR_CFG, 32'h0000_3400, rsp);
    run_cmd(32'h0000_0000, OP_LINK_STATUS);
    chk("no_fc_resp0", {RC_UNSUPPORTED, RS_UNKNOWN_CMD}, rd);
    wrap_up();
  end

  // a hang ends the run as a failure
  initial begin
    #(4 * 40000);
    num_errors++;
    wrap_up();
  end
endmodule : module_write_and_fc_link_status_tb
